//--- core/serial_frame_slave_port.sv
/*
 * Serial frame slave port: 16-bit frames framed by an active-low select,
 * input sampled on serial clock falls, output advanced on rises, plus
 * the function mux of the eight configurable io pins.
 * Assumes the serial clock is slow enough for 40 MHz oversampling and
 * that the core supplies the reply word before each frame starts.
 */
`timescale 1ns/1ps
module serial_frame_slave_port #(
    parameter int FRAME_W = serial_port_pkg::FRAME_BITS,
    parameter int PINS = serial_port_pkg::NUM_PINS
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_sclk,
    input wire logic i_sync_n,
    input wire logic i_serial_in,
    output logic o_serial_out,
    input wire logic [FRAME_W-1:0] i_tx_word,
    output logic [FRAME_W-1:0] o_rx_word,
    output logic o_rx_valid,
    output logic o_frame_active,
    input wire logic [PINS*serial_port_pkg::FUNC_W-1:0] i_pin_func,
    input wire logic [PINS-1:0] i_dig_out_value,
    input wire logic i_adc_busy,
    input wire logic [PINS-1:0] i_config_io_pin,
    output logic [PINS-1:0] o_config_io_pin,
    output logic [PINS-1:0] o_config_io_pin_oe,
    output logic [PINS-1:0] o_dac_en,
    output logic [PINS-1:0] o_adc_en,
    output logic [PINS-1:0] o_dig_in_value
);
    import serial_port_pkg::*;

    // ==========================================================
    // pin synchronisers; first stage feeds only the second
    logic sclk_meta, sclk_sync, sclk_prev;
    logic sync_meta, sync_sync, sync_prev;
    logic sin_meta, sin_sync;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sclk_meta <= 1'b0;
            sclk_sync <= 1'b0;
            sclk_prev <= 1'b0;
            sync_meta <= 1'b1;
            sync_sync <= 1'b1;
            sync_prev <= 1'b1;
            sin_meta <= 1'b0;
            sin_sync <= 1'b0;
        end else begin
            sclk_meta <= i_sclk;
            sclk_sync <= sclk_meta;
            sclk_prev <= sclk_sync;
            sync_meta <= i_sync_n;
            sync_sync <= sync_meta;
            sync_prev <= sync_sync;
            sin_meta <= i_serial_in;
            sin_sync <= sin_meta;
        end
    end

    // edge detection relies on the link clock staying far below mclk/2
    logic sclk_fall, sclk_rise, sync_fall, sync_low;
    assign sclk_fall = sclk_prev && !sclk_sync;
    assign sclk_rise = !sclk_prev && sclk_sync;
    assign sync_fall = sync_prev && !sync_sync;
    assign sync_low = !sync_sync;

    // ==========================================================
    // frame state
    frame_state_t state;
    frame_state_t next_state;
    logic [COUNT_W-1:0] bit_count;
    logic take_bit;

    assign take_bit = (state == ST_SHIFT) && sync_low && sclk_fall;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (sync_fall) begin
                    next_state = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (!sync_low) begin
                    next_state = ST_IDLE;
                end else if (take_bit && bit_count == COUNT_LAST - 5'h01) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!sync_low) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_frame_active <= 1'b0;
        end else begin
            o_frame_active <= (next_state == ST_SHIFT);
        end
    end

    // ==========================================================
    // receive path
    logic [FRAME_W-1:0] rx_shift;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bit_count <= COUNT_RESET;
        end else if (sync_fall) begin
            bit_count <= COUNT_RESET;
        end else if (take_bit) begin
            bit_count <= bit_count + 5'h01;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_shift <= WORD_RESET;
        end else if (take_bit) begin
            rx_shift <= {rx_shift[FRAME_W-2:0], sin_sync};
        end
    end

    // word handed over only when all sixteen bits arrived; short frames drop
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rx_word <= WORD_RESET;
            o_rx_valid <= 1'b0;
        end else begin
            o_rx_valid <= 1'b0;
            if (take_bit && bit_count == COUNT_LAST - 5'h01) begin
                o_rx_word <= {rx_shift[FRAME_W-2:0], sin_sync};
                o_rx_valid <= 1'b1;
            end
        end
    end

    // ==========================================================
    // transmit path
    logic [FRAME_W-1:0] tx_shift;
    logic fall_seen;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            fall_seen <= 1'b0;
        end else if (sync_fall || !sync_low) begin
            fall_seen <= 1'b0;
        end else if (sclk_fall) begin
            fall_seen <= 1'b1;
        end else if (sclk_rise) begin
            fall_seen <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tx_shift <= WORD_RESET;
            o_serial_out <= 1'b0;
        end else if (sync_fall) begin
            tx_shift <= {i_tx_word[FRAME_W-2:0], 1'b0};
            o_serial_out <= i_tx_word[FRAME_W-1];
        end else if (sync_low && fall_seen && sclk_rise) begin
            tx_shift <= {tx_shift[FRAME_W-2:0], 1'b0};
            o_serial_out <= tx_shift[FRAME_W-1];
        end
    end

    // ==========================================================
    // io pin function mux
    for (genvar p = 0; p < PINS; p++) begin : g_pin
        config_io_pin_mux #(
            .HAS_BUSY(p == BUSY_PIN)
        ) u_mux (
            .i_mclk(i_mclk),
            .i_reset_n(i_reset_n),
            .i_func(func_of(i_pin_func, p)),
            .i_dig_value(i_dig_out_value[p]),
            .i_busy(i_adc_busy),
            .i_pin(i_config_io_pin[p]),
            .o_pin_out(o_config_io_pin[p]),
            .o_pin_oe(o_config_io_pin_oe[p]),
            .o_dac_en(o_dac_en[p]),
            .o_adc_en(o_adc_en[p]),
            .o_pin_value(o_dig_in_value[p])
        );
    end

endmodule : serial_frame_slave_port

//--- core/serial_port_pkg.sv
/*
 * Constants and types shared by the serial frame slave port and its
 * per-pin function mux.
 * Assumes a single system clock; link pins arrive asynchronous to it.
 */
package serial_port_pkg;

    // ==========================================================
    // frame geometry
    localparam int FRAME_BITS = 16;
    localparam int COUNT_W = 5;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 5'h00;
    localparam logic [COUNT_W-1:0] COUNT_LAST = 5'h10;
    localparam logic [FRAME_BITS-1:0] WORD_RESET = 16'h0000;

    // ==========================================================
    // io pin layout
    localparam int NUM_PINS = 8;
    localparam int BUSY_PIN = 7;
    localparam int FUNC_W = 3;

    // ==========================================================
    // clock figures
    localparam int MCLK_PERIOD_NS = 25;
    localparam int SCLK_MAX_READ_MHZ = 20;
    localparam int SCLK_MAX_WRITE_MHZ = 50;

    typedef enum logic [FUNC_W-1:0] {
        FUNC_UNUSED = 3'h0,
        FUNC_DAC_OUT = 3'h1,
        FUNC_ADC_IN = 3'h2,
        FUNC_DIG_IN = 3'h3,
        FUNC_DIG_OUT = 3'h4,
        FUNC_BUSY = 3'h5
    } pin_func_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE = 3'b100
    } frame_state_t;

    // pick one pin's function field out of the packed configuration
    function automatic pin_func_t func_of(input logic [NUM_PINS*FUNC_W-1:0] cfg,
                                          input int pin);
        return pin_func_t'(cfg[pin*FUNC_W +: FUNC_W]);
    endfunction : func_of

endpackage : serial_port_pkg

//--- core/config_io_pin_mux.sv
/*
 * Function mux for one configurable io pin: converter output, converter
 * input, digital input, digital output, or (where allowed) busy flag.
 * Assumes the pin pad resolves level from o_pin_out and o_pin_oe.
 */
`timescale 1ns/1ps
module config_io_pin_mux #(
    parameter bit HAS_BUSY = 1'b0
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [serial_port_pkg::FUNC_W-1:0] i_func,
    input wire logic i_dig_value,
    input wire logic i_busy,
    input wire logic i_pin,
    output logic o_pin_out,
    output logic o_pin_oe,
    output logic o_dac_en,
    output logic o_adc_en,
    output logic o_pin_value
);
    import serial_port_pkg::*;

    pin_func_t func;
    logic pin_meta;
    logic busy_ok;

    assign func = pin_func_t'(i_func);
    // busy is only legal on the one pin that carries it; elsewhere it idles
    assign busy_ok = HAS_BUSY && (func == FUNC_BUSY);

    // ==========================================================
    // drive side
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pin_out <= 1'b0;
            o_pin_oe <= 1'b0;
            o_dac_en <= 1'b0;
            o_adc_en <= 1'b0;
        end else begin
            o_dac_en <= (func == FUNC_DAC_OUT);
            o_adc_en <= (func == FUNC_ADC_IN);
            o_pin_oe <= (func == FUNC_DIG_OUT) || busy_ok;
            o_pin_out <= busy_ok ? i_busy : (func == FUNC_DIG_OUT) && i_dig_value;
        end
    end

    // ==========================================================
    // read side, two stages since the pad is asynchronous
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_meta <= 1'b0;
            o_pin_value <= 1'b0;
        end else begin
            pin_meta <= i_pin;
            o_pin_value <= pin_meta;
        end
    end

endmodule : config_io_pin_mux

//--- bench/serial_frame_slave_port_sva.sv
/* Assertions on the serial frame slave port pins.
   Bound to its top module; sees only its ports. */
`timescale 1ns/1ps
module serial_frame_slave_port_sva import serial_port_pkg::*; #(
    parameter int FRAME_W = 16,
    parameter int PINS = 8
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_sclk,
    input wire logic i_sync_n,
    input wire logic o_serial_out,
    input wire logic [FRAME_W-1:0] i_tx_word,
    input wire logic [FRAME_W-1:0] o_rx_word,
    input wire logic o_rx_valid,
    input wire logic o_frame_active,
    input wire logic [PINS*serial_port_pkg::FUNC_W-1:0] i_pin_func,
    input wire logic i_adc_busy,
    input wire logic [PINS-1:0] o_config_io_pin,
    input wire logic [PINS-1:0] o_config_io_pin_oe
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);
    // ==========================================
    // cycles since the clock or select pin moved; edges take ~3 cycles to reach outputs
    logic [3:0] quiet;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            quiet <= 4'h0;
        end else if (i_sclk != $past(i_sclk) || i_sync_n != $past(i_sync_n)) begin
            quiet <= 4'h0;
        end else if (quiet != 4'hF) begin
            quiet <= quiet + 4'h1;
        end
    end
    chk_rx_one_cycle: assert property (o_rx_valid |=> !o_rx_valid)
        else $error("rx valid longer than one cycle");
    chk_start_needs_sync: assert property ($rose(o_frame_active) |-> !$past(i_sync_n, 2))
        else $error("frame opened without select");
    chk_msb_first: assert property ($rose(o_frame_active) |->
        ##[0:1] o_serial_out == i_tx_word[FRAME_W-1])
        else $error("reply msb missing at frame start");
    chk_out_holds: assert property (quiet > 4'h5 |-> $stable(o_serial_out))
        else $error("serial out moved without clock edge");
    chk_rx_holds: assert property (quiet > 4'h5 |-> !o_rx_valid && $stable(o_rx_word))
        else $error("rx changed without clock edge");
    chk_word_with_valid: assert property ($changed(o_rx_word) |->
        o_rx_valid || $past(o_rx_valid))
        else $error("rx word changed outside a frame end");
    chk_adc_no_drive: assert property ($past(i_pin_func[FUNC_W-1:0]) == FUNC_ADC_IN |->
        !o_config_io_pin_oe[0])
        else $error("converter input pin driven");
    chk_busy_pin: assert property ($past(i_pin_func[BUSY_PIN*FUNC_W +: FUNC_W]) == FUNC_BUSY
        |-> o_config_io_pin_oe[BUSY_PIN] && o_config_io_pin[BUSY_PIN] == $past(i_adc_busy))
        else $error("busy pin not following busy");
    cover property ($rose(o_frame_active));
    cover property (o_rx_valid);
    cover property ($past(i_pin_func[BUSY_PIN*FUNC_W +: FUNC_W]) == FUNC_BUSY && i_adc_busy);
endmodule : serial_frame_slave_port_sva

bind serial_frame_slave_port serial_frame_slave_port_sva #(.FRAME_W(FRAME_W), .PINS(PINS)) chk (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_sclk(i_sclk), .i_sync_n(i_sync_n),
    .o_serial_out(o_serial_out), .i_tx_word(i_tx_word), .o_rx_word(o_rx_word),
    .o_rx_valid(o_rx_valid), .o_frame_active(o_frame_active), .i_pin_func(i_pin_func),
    .i_adc_busy(i_adc_busy), .o_config_io_pin(o_config_io_pin),
    .o_config_io_pin_oe(o_config_io_pin_oe)
);

//--- bench/serial_master_model.sv
/* Behavioural serial bus controller driving the port's link pins.
   Assumes the bench asks for one frame at a time. */
`timescale 1ns/1ps
module serial_master_model (
    output logic o_sclk,
    output logic o_sync_n,
    output logic o_serial_in,
    input wire logic i_serial_out
);
    initial begin
        o_sclk = 1'b0;
        o_sync_n = 1'b1;
        o_serial_in = 1'b0;
    end
    // ==========================================
    // 200 ns clock at or below the read limit; data moves 100 ns after each fall
    task automatic frame(input logic [15:0] d, input int n, input bit hi,
                         output logic [15:0] q);
        q = 16'h0000;
        o_sclk = hi;
        #200 o_sync_n = 1'b0;
        o_serial_in = d[15];
        #200;
        for (int k = 0; k < n; k++) begin
            o_sclk = ~o_sclk;
            #100;
            if (hi) begin
                q = {q[14:0], i_serial_out};
                d = {d[14:0], ~d[15]};
                o_serial_in = d[15];
            end
            o_sclk = ~o_sclk;
            #100;
            if (!hi) begin
                q = {q[14:0], i_serial_out};
                d = {d[14:0], ~d[15]};
                o_serial_in = d[15];
            end
        end
        o_sync_n = 1'b1;
        o_serial_in = ~o_serial_in; // toggled line, not a held value
    endtask : frame
    // stray clock pulses while not selected
    task automatic stray(input int n);
        repeat (2 * n) #100 o_sclk = ~o_sclk;
    endtask : stray
endmodule : serial_master_model

//--- bench/test_serial_frame_slave_port.sv
/* Self-checking bench of the serial frame slave port and its pin mux.
   Assumes the master model and the bound checker. */
`timescale 1ns/1ps
module test_serial_frame_slave_port;
    import serial_port_pkg::*;
    logic i_mclk = 1'b0;
    logic i_reset_n = 1'b0;
    logic sclk, sync_n, serial_in, serial_out, valid, active;
    logic busy = 1'b0;
    logic [15:0] tx = 16'h0000, rx, q;
    logic [23:0] func = 24'h000000;
    logic [7:0] dov = 8'h00, pin = 8'h00, pout, poe, dac, adc, din;
    int bad_count = 0, checks = 0, e, f, d;
    logic [15:0] exp_q[$];
    logic act_d = 1'b0;
    always #12.5 i_mclk = ~i_mclk;
    serial_frame_slave_port uut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_sclk(sclk),
        .i_sync_n(sync_n), .i_serial_in(serial_in), .o_serial_out(serial_out), .i_tx_word(tx),
        .o_rx_word(rx), .o_rx_valid(valid), .o_frame_active(active), .i_pin_func(func),
        .i_dig_out_value(dov), .i_adc_busy(busy), .i_config_io_pin(pin),
        .o_config_io_pin(pout), .o_config_io_pin_oe(poe), .o_dac_en(dac), .o_adc_en(adc),
        .o_dig_in_value(din));
    serial_master_model m (.o_sclk(sclk), .o_sync_n(sync_n), .o_serial_in(serial_in),
        .i_serial_out(serial_out));
    task automatic compare(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : compare
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    task automatic drain();
        for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge i_mclk);
        if (exp_q.size() > 0) begin
            bad_count++;
            conclude();
        end
    endtask : drain
    // ==========================================
    // every completed frame must match the oldest word sent;
    // looked at on the falling edge, clear of the edge that launches it
    always @(negedge i_mclk) begin
        if (valid === 1'b1) begin
            compare("rx_pending", exp_q.size() > 0, 1'b1);
            compare("rx_word", rx, exp_q.pop_front());
            compare("active_span", {act_d, active}, 2'b10);
        end
        act_d = active;
    end
    initial begin
        void'($urandom(32'h0CD07A01));
        repeat (3) @(negedge i_mclk);
        i_reset_n = 1'b1;
        repeat (4) @(negedge i_mclk);
        compare("idle", {poe, serial_out, valid, active}, 24'h000000);
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            if (i == 4) begin
                m.frame(16'hFFFF, 9, 1'b1, q);
                m.stray(5);
                repeat (8) @(negedge i_mclk);
                compare("rx_kept", rx, e[15:0]);
            end
            tx = 16'($urandom());
            e = $urandom();
            exp_q.push_back(e[15:0]);
            m.frame(e[15:0], FRAME_BITS, i[0], q);
            compare("reply", q, tx);
            drain();
        end
        $display("frame test done");
        for (int i = 0; i < 24; i++) begin
            for (int p = 0; p < NUM_PINS; p++) func[FUNC_W*p +: FUNC_W] = 3'($urandom_range(5));
            dov = 8'($urandom());
            pin = 8'($urandom());
            busy = 1'($urandom());
            repeat (3) @(negedge i_mclk);
            for (int p = 0; p < NUM_PINS; p++) begin
                f = func[FUNC_W*p +: FUNC_W];
                d = (f == FUNC_DIG_OUT) || (f == FUNC_BUSY && p == BUSY_PIN);
                compare("oe", poe[p], d[0]);
                if (d) compare("drive", pout[p], f == FUNC_DIG_OUT ? dov[p] : busy);
                compare("dac_adc", {dac[p], adc[p]}, {f == FUNC_DAC_OUT, f == FUNC_ADC_IN});
            end
            compare("dig_in", din, pin);
            @(negedge i_mclk);
        end
        $display("pin test done");
        conclude();
    end
endmodule : test_serial_frame_slave_port
